/* File: alarm_warning_manager_tb.sv */
// Self-checking bench for the alarm and warning manager.
`timescale 1ns/10ps
`include "awm_map.vh"
module alarm_warning_manager_tb;
  localparam int HALF = 4;
  reg         clk, resetn, cyc, stb, we, net_disc, running, conv, clr, gear;
  reg  [7:0]  adr, temp, volt;
  reg  [3:0]  sel, baud;
  reg  [31:0] wdat;
  reg  [15:0] pos_dev;
  wire [31:0] rdat;
  wire        ack, ser_err, ser_ok, warn, alarm, excite, brake, led;
  int         num_errors, check_count, n;
  logic [71:0] note_q[$];   // Address, mask and expected read data.
  logic [7:0]  hq[$];       // Expected history, newest first.
  logic [71:0] note;
  logic        prev;

  awm_top #(.TICK_CYCLES(4), .BLINK_HALF_CYCLES(HALF)) u_dut (
    .CLK(clk), .RESETN(resetn), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
    .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack), .NET_DISCONNECT(net_disc),
    .MOTOR_RUNNING(running), .CONV_ALARM(conv), .BAUD_SW(baud), .ALARM_CLEAR_INPUT(clr),
    .SER_ERR(ser_err), .SER_OK(ser_ok), .TEMP(temp), .VOLT(volt), .POS_DEV(pos_dev),
    .GEAR_RES_BAD(gear), .WARNING_OUTPUT(warn), .ALARM_OUTPUT(alarm), .EXCITE(excite),
    .BRAKE_ENGAGE(brake), .FAULT_LED(led));
  awm_master_model u_master (.clk(clk), .ser_err(ser_err), .ser_ok(ser_ok));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts one comparison and reports a difference at once.
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Classic single cycle; the request stands until ack is sampled high.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h3, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    note_q.push_back({a, m, e & m});
    wb(1'b0, a, 32'h0);
  endtask
  // The history index needs one cycle before its entry can be read.
  task hist(input int i, input logic [7:0] e);
    wb(1'b1, `AWM_ADR_HIDX, i);
    wt(1);
    rd(`AWM_ADR_HDAT, {24'h0, e}, 32'hff);
  endtask
  task rec(input logic [7:0] c);
    hq.push_front(c);
    if (hq.size() > 10) hq.pop_back();   // Oldest entry is discarded.
  endtask
  task press;
    @(posedge clk) clr <= 1'b1;
    wt(4);
    @(posedge clk) clr <= 1'b0;
    wt(5);
  endtask
  task do_reset;
    @(posedge clk) resetn <= 1'b0;
    wt(3);
    @(posedge clk) resetn <= 1'b1;
    wt(2);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Takes the oldest note whenever the slave returns read data.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && note_q.size() > 0) begin
      note = note_q.pop_front();
      chk($sformatf("reg %h", note[71:64]), note[31:0], rdat & note[63:32]);
    end
  end

  // Cuts a hang short; the whole sequence needs under 3000 cycles.
  initial begin
    #(25 * 5000);
    num_errors++;
    stop_test;
  end

  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    {net_disc, running, conv, clr, gear} = '0;
    {baud, temp, volt, pos_dev, resetn} = {4'h3, 8'h40, 8'h80, 16'h0100, 1'b0};
    num_errors = 0;
    check_count = 0;
    void'($urandom(72));
    wt(2);
    resetn <= 1'b1;   // Reset is held for two cycles at the start.
    wt(2);
    rd(`AWM_ADR_ERRTH, 32'h03, 32'hff);
    rd(`AWM_ADR_TEMPLV, 32'hc8, 32'hff);
    rd(`AWM_ADR_OVLV, 32'hf0, 32'hff);
    rd(`AWM_ADR_UVLV, 32'h20, 32'hff);
    rd(`AWM_ADR_BAND, 32'h0100, 32'hffff);
    rd(`AWM_ADR_WNGST, 32'h0, 32'hffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    chk("excite", 1, excite);
    // Warnings: random values stay clear of every level first.
    @(posedge clk) {temp, volt} <= {8'($urandom_range(8'hc7, 0)), 8'($urandom_range(8'hf0, 8'h20))};
    wt(3);
    chk("warn", 0, warn);
    @(posedge clk) temp <= 8'hff;
    wt(3);
    rec(`AWM_WNG_HEAT);
    chk("warn", 1, warn);
    rd(`AWM_ADR_WNGST, 32'h1 << `AWM_W_HEAT, 32'h3f);
    @(posedge clk) temp <= 8'hc7;
    wt(3);
    chk("warn", 0, warn);
    @(posedge clk) volt <= 8'hf1;
    wt(3);
    rec(`AWM_WNG_OV);
    chk("warn", 1, warn);
    @(posedge clk) volt <= 8'h1f;
    wt(3);
    rec(`AWM_WNG_UV);
    @(posedge clk) volt <= 8'h20;
    wt(3);
    chk("warn", 0, warn);
    u_master.send_bad(1, 0);
    wt(2);
    rec(`AWM_WNG_COMM);
    chk("warn", 1, warn);
    u_master.send_good;
    wt(3);
    chk("warn", 0, warn);
    wb(1'b1, `AWM_ADR_CTRL, 32'h2);
    wt(3);
    rec(`AWM_WNG_STEP);
    chk("warn", 1, warn);
    @(posedge clk) pos_dev <= 16'h00ff;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) gear <= 1'b1;
      wt(3);
      chk("excite", 1, excite);
      rec(`AWM_WNG_GEAR);
      @(posedge clk) gear <= 1'b0;
      wt(3);
    end
    rd(`AWM_ADR_WNGST, 32'ha00, 32'hf3f);
    foreach (hq[i]) hist(i, hq[i]);
    wb(1'b1, `AWM_ADR_CMD, 32'h1);
    rd(`AWM_ADR_WNGST, 32'h0, 32'hf00);
    hist(0, 8'h00);
    // Consecutive errors reach the threshold with a brake fitted.
    wb(1'b1, `AWM_ADR_CTRL, 32'h1);
    u_master.send_bad(3, 2);
    wt(4);
    chk("excite", 0, excite);
    chk("brake", 1, brake);
    rd(`AWM_ADR_ALMST, 32'h184, 32'h7ff);
    wt(10);
    n = 0;
    prev = led;
    repeat (HALF * (2 * 7 + 6)) begin
      @(posedge clk);
      if (led === 1'b1 && prev === 1'b0) n++;
      prev = led;
    end
    chk("blinks", 7, n);
    do_reset;
    // Bad baud switch: excitation off and the clear input has no effect.
    @(posedge clk) baud <= 4'ha;
    wt(6);
    rd(`AWM_ADR_ALMST, 32'h183, 32'h7ff);
    chk("brake", 0, brake);
    press;
    chk("alarm", 1, alarm);
    @(posedge clk) baud <= 4'h9;
    do_reset;
    // Clearable alarms that keep excitation.
    @(posedge clk) net_disc <= 1'b1;
    wt(6);
    chk("alarm", 0, alarm);
    @(posedge clk) running <= 1'b1;
    wt(6);
    rd(`AWM_ADR_ALMST, 32'h781, 32'h7ff);
    chk("excite", 1, excite);
    @(posedge clk) net_disc <= 1'b0;
    press;
    chk("alarm", 0, alarm);
    @(posedge clk) conv <= 1'b1;
    wt(6);
    rd(`AWM_ADR_ALMST, 32'h78e, 32'h7ff);
    @(posedge clk) conv <= 1'b0;
    press;
    u_master.send_good;
    wb(1'b1, `AWM_ADR_TMO, 32'h2);
    chk("alarm", 0, alarm);
    wt(20);
    rd(`AWM_ADR_ALMST, 32'h785, 32'h7ff);
    chk("excite", 1, excite);
    wb(1'b1, `AWM_ADR_TMO, 32'h0);
    u_master.send_good;
    press;
    chk("alarm", 0, alarm);
    wt(3);
    stop_test;
  end
endmodule // alarm_warning_manager_tb

/* File: awm_asserts.sv */
// Port checker for the alarm and warning manager.
`timescale 1ns/10ps
module awm_asserts #(
  parameter TICK_CYCLES       = 4,
  parameter BLINK_HALF_CYCLES = 4
) (
  input wire        CLK,
  input wire        RESETN,
  input wire        WB_CYC,
  input wire        WB_STB,
  input wire        WB_ACK,
  input wire        NET_DISCONNECT,
  input wire        MOTOR_RUNNING,
  input wire        CONV_ALARM,
  input wire [3:0]  BAUD_SW,
  input wire        SER_ERR,
  input wire [7:0]  TEMP,
  input wire        GEAR_RES_BAD,
  input wire        WARNING_OUTPUT,
  input wire        ALARM_OUTPUT,
  input wire        EXCITE,
  input wire        BRAKE_ENGAGE,
  input wire        FAULT_LED
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  ack_next_a: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK) else $error("bus request not acked");
  ack_pulse_a: assert property (WB_ACK |=> !WB_ACK) else $error("ack longer than one cycle");
  excite_cut_a: assert property ($fell(EXCITE) |-> ALARM_OUTPUT)
    else $error("excitation cut without alarm");
  brake_hold_a: assert property (BRAKE_ENGAGE |-> ALARM_OUTPUT && !EXCITE)
    else $error("brake engaged while excited");
  excite_kept_a: assert property (ALARM_OUTPUT && EXCITE |=> EXCITE || !ALARM_OUTPUT)
    else $error("kept excitation dropped");
  net_alarm_a: assert property ((NET_DISCONNECT && MOTOR_RUNNING) [*6] |-> ALARM_OUTPUT)
    else $error("disconnect raised no alarm");
  baud_alarm_a: assert property ((BAUD_SW > 4'h9) [*6] |-> ALARM_OUTPUT)
    else $error("bad baud raised no alarm");
  conv_alarm_a: assert property (CONV_ALARM [*6] |-> ALARM_OUTPUT)
    else $error("converter alarm missed");
  heat_warn_a: assert property (TEMP == 8'hff |-> ##1 WARNING_OUTPUT)
    else $error("heat warning missing");
  gear_warn_a: assert property (GEAR_RES_BAD |-> ##1 WARNING_OUTPUT)
    else $error("gear warning missing");
  ser_warn_a: assert property (SER_ERR |-> ##[1:3] WARNING_OUTPUT)
    else $error("serial warning missing");
  led_idle_a: assert property (!ALARM_OUTPUT [*3] |-> !FAULT_LED) else $error("indicator lit without alarm");

  // Main scenarios: an excitation cut, a warning and a lit indicator.
  cover property ($fell(EXCITE));
  cover property ($rose(WARNING_OUTPUT));
  cover property ($rose(FAULT_LED));
endmodule // awm_asserts

bind awm_top awm_asserts #(.TICK_CYCLES(TICK_CYCLES), .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_asserts (
  .CLK(CLK), .RESETN(RESETN), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_ACK(WB_ACK),
  .NET_DISCONNECT(NET_DISCONNECT), .MOTOR_RUNNING(MOTOR_RUNNING), .CONV_ALARM(CONV_ALARM),
  .BAUD_SW(BAUD_SW), .SER_ERR(SER_ERR), .TEMP(TEMP), .GEAR_RES_BAD(GEAR_RES_BAD),
  .WARNING_OUTPUT(WARNING_OUTPUT), .ALARM_OUTPUT(ALARM_OUTPUT), .EXCITE(EXCITE),
  .BRAKE_ENGAGE(BRAKE_ENGAGE), .FAULT_LED(FAULT_LED));

/* File: awm_blink.v */
// Fault indicator driver: blinks a count of times, pauses, repeats.
`timescale 1ns/10ps
`include "awm_map.vh"

module awm_blink #(
  parameter HALF_CYCLES = 8000000
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       run,
  input  wire [3:0] count,
  output reg        led
);

  reg [22:0] timer; // Cycles within one half period.
  reg [4:0]  step;  // Half periods within one blink group.
  wire       half_done = (timer == HALF_CYCLES[22:0] - 23'h000001);
  wire [4:0] span      = {count, 1'b0} + `AWM_BLINK_GAP;

  // A zero count means steady light; otherwise pulses and a dark gap.
  always @(posedge clk) begin
    if (!resetn || !run) begin
      timer <= 23'h000000;
      step  <= 5'h00;
      led   <= 1'b0;
    end else begin
      timer <= half_done ? 23'h000000 : timer + 23'h000001;
      if (half_done) begin
        step <= (step + 5'h01 >= span) ? 5'h00 : step + 5'h01;
      end
      if (count == `AWM_BLINK_NONE) begin
        led <= 1'b1;
      end else begin
        led <= (step < {count, 1'b0}) && !step[0];
      end
    end
  end

endmodule // awm_blink

/* File: awm_hist_mem.v */
// Ten-entry warning history store with a registered read port.
`timescale 1ns/10ps
`include "awm_map.vh"

module awm_hist_mem (
  input  wire       clk,
  input  wire       resetn,
  input  wire       we,
  input  wire [3:0] waddr,
  input  wire [7:0] wdata,
  input  wire [3:0] raddr,
  output reg  [7:0] rdata
);

  // Storage has no reset; emptiness is tracked by the fill count upstairs.
  reg [7:0] mem [0:`AWM_HIST_DEPTH-1];

  // One write port and one registered read port.
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // awm_hist_mem

/* File: awm_map.vh */
// Register map, codes and timing constants of the alarm and warning manager.
`ifndef AWM_MAP_VH
`define AWM_MAP_VH

// Clock rate and the times that are derived from it.
`define AWM_CLK_HZ        40000000
`define AWM_MS_PER_S      1000
`define AWM_TICK_MS       1
`define AWM_BLINK_HALF_MS 200

// Register byte offsets on the bus.
`define AWM_ADR_CTRL   8'h00
`define AWM_ADR_CMD    8'h04
`define AWM_ADR_ERRTH  8'h08
`define AWM_ADR_TMO    8'h0c
`define AWM_ADR_TEMPLV 8'h10
`define AWM_ADR_OVLV   8'h14
`define AWM_ADR_UVLV   8'h18
`define AWM_ADR_BAND   8'h1c
`define AWM_ADR_ALMST  8'h20
`define AWM_ADR_WNGST  8'h24
`define AWM_ADR_HIDX   8'h28
`define AWM_ADR_HDAT   8'h2c

// Field positions.
`define AWM_CTRL_BRAKE   0
`define AWM_CTRL_STEPW   1
`define AWM_CMD_HCLR     0
`define AWM_ALM_ACTIVE   8
`define AWM_ALM_EXCITE   9
`define AWM_ALM_RESET    10
`define AWM_WNG_CNT_LSB  8

// Reset values.
`define AWM_RST_CTRL   2'h0
`define AWM_RST_ERRTH  8'h03
`define AWM_RST_TMO    16'h0000
`define AWM_RST_TEMPLV 8'hc8
`define AWM_RST_OVLV   8'hf0
`define AWM_RST_UVLV   8'h20
`define AWM_RST_BAND   16'h0100

// Alarm codes.
`define AWM_ALM_NET    8'h81
`define AWM_ALM_BAUD   8'h83
`define AWM_ALM_COMM   8'h84
`define AWM_ALM_TMO    8'h85
`define AWM_ALM_CONV   8'h8e

// Warning codes and their slots.
`define AWM_WNG_STEP   8'h10
`define AWM_WNG_HEAT   8'h21
`define AWM_WNG_OV     8'h22
`define AWM_WNG_UV     8'h25
`define AWM_WNG_GEAR   8'h71
`define AWM_WNG_COMM   8'h84
`define AWM_W_STEP     0
`define AWM_W_HEAT     1
`define AWM_W_OV       2
`define AWM_W_UV       3
`define AWM_W_GEAR     4
`define AWM_W_COMM     5
`define AWM_NWARN      6

// Miscellaneous limits.
`define AWM_HIST_DEPTH 10
`define AWM_BAUD_MAX   4'h9
`define AWM_BLINK_COMM 4'h7
`define AWM_BLINK_NONE 4'h0
`define AWM_BLINK_GAP  5'h06

`endif

/* File: awm_master_model.sv */
// Serial-link master model that delivers good and corrupted frames.
`timescale 1ns/10ps
module awm_master_model (
  input  wire clk,
  output reg  ser_err,
  output reg  ser_ok
);
  initial begin
    ser_err = 1'b0;
    ser_ok  = 1'b0;
  end
  // Sends n corrupted frames; gap idles between them, so it can be prompt or slow.
  task send_bad(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) ser_err <= 1'b1;
      @(posedge clk) ser_err <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
  // One good frame, which ends any error streak and restarts the idle timer.
  task send_good;
    @(posedge clk) ser_ok <= 1'b1;
    @(posedge clk) ser_ok <= 1'b0;
  endtask
endmodule // awm_master_model

/* File: awm_top.v */
// Alarm and warning manager of a motor driver, with a Wishbone register slave.
// Summary of operation
// - Excitation-off alarm cuts winding current immediately.
// - Excitation-off alarm engages fitted brake automatically.
// - Excitation-on alarm keeps winding current flowing.
// - Converter master disconnect while running raises 81h.
// - Invalid baud switch raises 83h, not clearable.
// - Consecutive errors reaching threshold raise 84h, blink 7.
// - Communication timeout elapsing raises clearable 85h.
// - Network converter alarm raises 8Eh.
// - Any warning asserts warning output; motion continues.
// - Warning output drops by itself when cause clears.
// - Keep ten latest warnings, newest first.
// - Master reads history, clears it by command.
// - History volatile, empty after power-up.
// - Step-out deviation reaching band raises warning 10h.
// - Temperature reaching level raises warning 21h.
// - Voltage above overvoltage level raises warning 22h.
// - Voltage below undervoltage level raises warning 25h.
// - Gear resolution out of range raises 71h.
// - Each serial error raises warning 84h.
`timescale 1ns/10ps
`include "awm_map.vh"

module awm_top #(
  parameter TICK_CYCLES       = `AWM_CLK_HZ / `AWM_MS_PER_S * `AWM_TICK_MS,
  parameter BLINK_HALF_CYCLES = `AWM_CLK_HZ / `AWM_MS_PER_S * `AWM_BLINK_HALF_MS
) (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire        WB_CYC,
  input  wire        WB_STB,
  input  wire        WB_WE,
  input  wire [7:0]  WB_ADR,
  input  wire [3:0]  WB_SEL,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK,
  input  wire        NET_DISCONNECT,
  input  wire        MOTOR_RUNNING,
  input  wire        CONV_ALARM,
  input  wire [3:0]  BAUD_SW,
  input  wire        ALARM_CLEAR_INPUT,
  input  wire        SER_ERR,
  input  wire        SER_OK,
  input  wire [7:0]  TEMP,
  input  wire [7:0]  VOLT,
  input  wire [15:0] POS_DEV,
  input  wire        GEAR_RES_BAD,
  output reg         WARNING_OUTPUT,
  output reg         ALARM_OUTPUT,
  output reg         EXCITE,
  output reg         BRAKE_ENGAGE,
  output wire        FAULT_LED
);

  // Wraps a history position of up to one lap past the end back into the ten slots.
  function [3:0] awm_wrap;
    input [4:0] v;
    begin
      awm_wrap = (v >= `AWM_HIST_DEPTH) ? v[3:0] - 4'ha : v[3:0];
    end
  endfunction

  // Maps a warning slot to the code that the history records.
  function [7:0] awm_wcode;
    input [2:0] i;
    begin
      case (i)
        `AWM_W_STEP: awm_wcode = `AWM_WNG_STEP;
        `AWM_W_HEAT: awm_wcode = `AWM_WNG_HEAT;
        `AWM_W_OV:   awm_wcode = `AWM_WNG_OV;
        `AWM_W_UV:   awm_wcode = `AWM_WNG_UV;
        `AWM_W_GEAR: awm_wcode = `AWM_WNG_GEAR;
        default:     awm_wcode = `AWM_WNG_COMM;
      endcase
    end
  endfunction

  // Software settings.
  reg  [1:0]  ctrl;        // Brake fitted and step-out-as-warning mode.
  reg  [7:0]  err_th;      // Consecutive-error alarm threshold, zero disables.
  reg  [15:0] tmo_ms;      // Communication timeout in ms, zero disables.
  reg  [7:0]  temp_lv;     // Overheat warning level.
  reg  [7:0]  ov_lv;       // Overvoltage warning level.
  reg  [7:0]  uv_lv;       // Undervoltage warning level.
  reg  [15:0] band;        // Step-out detection band.
  reg  [3:0]  hidx;        // History read index, zero is newest.

  // Pin synchronisers; stage one feeds stage two and nothing else.
  reg  [7:0]  sync1;
  reg  [7:0]  sync2;
  wire        net_disc  = sync2[0];
  wire        motor_run = sync2[1];
  wire        conv_alm  = sync2[2];
  wire        clr_pin   = sync2[3];
  wire [3:0]  baud      = sync2[7:4];
  reg         clr_pin_q;   // Previous clear pin level for edge detection.

  // Communication supervision.
  reg  [7:0]  err_cnt;     // Consecutive serial errors, saturating.
  reg  [15:0] tick;        // Cycle counter for the millisecond tick.
  reg  [15:0] idle_ms;     // Milliseconds since the last good frame.

  // Alarm state.
  reg         alm_active;  // An alarm is latched.
  reg  [7:0]  alm_code;    // Code of the latched alarm.
  reg         alm_excite;  // Latched alarm keeps the motor excited.
  reg         alm_reset;   // Latched alarm may be cleared by the input.
  reg  [3:0]  blink_cnt;   // Blink count of the latched alarm.

  // Warning state and history bookkeeping.
  wire [`AWM_NWARN-1:0] wcond;  // Present warning conditions.
  wire [`AWM_NWARN-1:0] wevt;   // New warning events this cycle.
  reg  [`AWM_NWARN-1:0] wcond_q;
  reg  [`AWM_NWARN-1:0] pend;   // Events waiting to be written.
  reg  [2:0]  next_sel;
  reg         next_hit;
  reg  [3:0]  head;        // Slot that the next entry goes into.
  reg  [3:0]  hcount;      // Entries held, at most ten.
  reg         hvalid;      // Index pointed at a held entry last cycle.
  wire [7:0]  hdata;       // Registered memory output.

  // Bus decode.
  wire        req      = WB_CYC && WB_STB && !WB_ACK;
  wire        wr       = WB_CYC && WB_STB && WB_WE && WB_ACK;  // Commits at the edge where the master sees ack.
  wire        hist_clr = wr && (WB_ADR == `AWM_ADR_CMD) && WB_SEL[0] && WB_DAT_I[`AWM_CMD_HCLR];

  // Two-flop synchroniser for the disconnect, running, converter, clear and baud pins; other inputs go direct.
  always @(posedge CLK) begin
    if (!RESETN) begin
      sync1     <= 8'h00;
      sync2     <= 8'h00;
      clr_pin_q <= 1'b0;
    end else begin
      sync1     <= {BAUD_SW, ALARM_CLEAR_INPUT, CONV_ALARM, MOTOR_RUNNING, NET_DISCONNECT};
      sync2     <= sync1;
      clr_pin_q <= clr_pin;
    end
  end

  // Consecutive error counter and the idle timer; a good frame restarts both.
  always @(posedge CLK) begin
    if (!RESETN) begin
      err_cnt <= 8'h00;
      tick    <= 16'h0000;
      idle_ms <= 16'h0000;
    end else begin
      if (SER_ERR) begin
        err_cnt <= (err_cnt == 8'hff) ? err_cnt : err_cnt + 8'h01;
      end else if (SER_OK) begin
        err_cnt <= 8'h00;
      end
      if (SER_OK) begin
        tick    <= 16'h0000;
        idle_ms <= 16'h0000;
      end else if (tick == TICK_CYCLES[15:0] - 16'h0001) begin
        tick    <= 16'h0000;
        idle_ms <= (idle_ms == 16'hffff) ? idle_ms : idle_ms + 16'h0001;
      end else begin
        tick <= tick + 16'h0001;
      end
    end
  end

  // Alarm causes, in falling priority when several appear together.
  wire a_baud = (baud > `AWM_BAUD_MAX);
  wire a_comm = (err_th != 8'h00) && (err_cnt >= err_th);
  wire a_conv = conv_alm;
  wire a_net  = net_disc && motor_run;
  wire a_tmo  = (tmo_ms != 16'h0000) && (idle_ms >= tmo_ms);

  // The first alarm latches; the clear input only frees the clearable ones.
  // A cause that persists simply latches again on the following cycle.
  always @(posedge CLK) begin
    if (!RESETN) begin
      alm_active <= 1'b0;
      alm_code   <= 8'h00;
      alm_excite <= 1'b1;
      alm_reset  <= 1'b0;
      blink_cnt  <= `AWM_BLINK_NONE;
    end else if (!alm_active) begin
      alm_active <= a_baud || a_comm || a_conv || a_net || a_tmo;
      blink_cnt  <= `AWM_BLINK_NONE;
      if (a_baud) begin
        alm_code   <= `AWM_ALM_BAUD;
        alm_excite <= 1'b0;
        alm_reset  <= 1'b0;
      end else if (a_comm) begin
        alm_code   <= `AWM_ALM_COMM;
        alm_excite <= 1'b0;
        alm_reset  <= 1'b0;
        blink_cnt  <= `AWM_BLINK_COMM;
      end else if (a_conv) begin
        alm_code   <= `AWM_ALM_CONV;
        alm_excite <= 1'b1;
        alm_reset  <= 1'b1;
      end else if (a_net) begin
        alm_code   <= `AWM_ALM_NET;
        alm_excite <= 1'b1;
        alm_reset  <= 1'b1;
      end else if (a_tmo) begin
        alm_code   <= `AWM_ALM_TMO;
        alm_excite <= 1'b1;
        alm_reset  <= 1'b1;
      end
    end else if (alm_reset && clr_pin && !clr_pin_q) begin
      alm_active <= 1'b0;
      alm_excite <= 1'b1;
    end
  end

  // Motor power and brake follow the latched alarm class.
  always @(posedge CLK) begin
    if (!RESETN) begin
      EXCITE       <= 1'b0;
      BRAKE_ENGAGE <= 1'b0;
      ALARM_OUTPUT <= 1'b0;
    end else begin
      EXCITE       <= !alm_active || alm_excite;
      BRAKE_ENGAGE <= alm_active && !alm_excite && ctrl[`AWM_CTRL_BRAKE];
      ALARM_OUTPUT <= alm_active;
    end
  end

  // Warning conditions are plain levels of their causes.
  assign wcond[`AWM_W_STEP] = ctrl[`AWM_CTRL_STEPW] && (POS_DEV >= band);
  assign wcond[`AWM_W_HEAT] = (TEMP >= temp_lv);
  assign wcond[`AWM_W_OV]   = (VOLT > ov_lv);
  assign wcond[`AWM_W_UV]   = (VOLT < uv_lv);
  assign wcond[`AWM_W_GEAR] = GEAR_RES_BAD;
  assign wcond[`AWM_W_COMM] = (err_cnt != 8'h00);

  // Level warnings record on their rising edge; the serial one on every error.
  genvar g;
  generate
    for (g = 0; g < `AWM_NWARN; g = g + 1) begin : g_evt
      if (g == `AWM_W_COMM) begin : g_pulse
        assign wevt[g] = SER_ERR;
      end else begin : g_edge
        assign wevt[g] = wcond[g] && !wcond_q[g];
      end
    end
  endgenerate

  // Lowest slot with a pending event is written first, one per cycle.
  always @* begin : p_pick
    integer k;
    next_sel = 3'h0;
    next_hit = 1'b0;
    for (k = `AWM_NWARN - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        next_sel = k[2:0];
        next_hit = 1'b1;
      end
    end
  end

  // Pending events: a new event wins over the grant that retires it.
  // The warning output is a pure level, so it falls with its causes.
  always @(posedge CLK) begin
    if (!RESETN) begin
      wcond_q        <= {`AWM_NWARN{1'b0}};
      pend           <= {`AWM_NWARN{1'b0}};
      WARNING_OUTPUT <= 1'b0;
    end else begin
      wcond_q        <= wcond;
      pend           <= (pend & ~({{(`AWM_NWARN-1){1'b0}}, next_hit} << next_sel)) | wevt;
      WARNING_OUTPUT <= |wcond;
    end
  end

  // Circular history; the count starts at zero, so nothing survives power-up.
  // A write in the same cycle as a clear becomes the only entry.
  always @(posedge CLK) begin
    if (!RESETN) begin
      head   <= 4'h0;
      hcount <= 4'h0;
    end else if (hist_clr) begin
      head   <= next_hit ? 4'h1 : 4'h0;
      hcount <= next_hit ? 4'h1 : 4'h0;
    end else if (next_hit) begin
      head   <= awm_wrap({1'b0, head} + 5'h01);
      hcount <= (hcount == `AWM_HIST_DEPTH) ? hcount : hcount + 4'h1;
    end
  end

  // Entry n counted from the newest sits n+1 slots behind the head.
  wire [3:0] raddr = awm_wrap({1'b0, head} + 5'h09 - {1'b0, hidx});

  awm_hist_mem u_mem (
    .clk    (CLK),
    .resetn (RESETN),
    .we     (next_hit),
    .waddr  (hist_clr ? 4'h0 : head),
    .wdata  (awm_wcode(next_sel)),
    .raddr  (raddr),
    .rdata  (hdata)
  );

  // Fault indicator blinks the latched alarm's count.
  awm_blink #(
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_blink (
    .clk    (CLK),
    .resetn (RESETN),
    .run    (alm_active),
    .count  (blink_cnt),
    .led    (FAULT_LED)
  );

  // Register writes; byte lane zero carries every field, lane one the upper half.
  // Out-of-range history indexes are ignored so the read address stays in range.
  always @(posedge CLK) begin
    if (!RESETN) begin
      ctrl    <= `AWM_RST_CTRL;
      err_th  <= `AWM_RST_ERRTH;
      tmo_ms  <= `AWM_RST_TMO;
      temp_lv <= `AWM_RST_TEMPLV;
      ov_lv   <= `AWM_RST_OVLV;
      uv_lv   <= `AWM_RST_UVLV;
      band    <= `AWM_RST_BAND;
      hidx    <= 4'h0;
      hvalid  <= 1'b0;
    end else begin
      hvalid <= (hidx < hcount);
      if (wr && WB_SEL[0]) begin
        case (WB_ADR)
          `AWM_ADR_CTRL:   ctrl    <= WB_DAT_I[1:0];
          `AWM_ADR_ERRTH:  err_th  <= WB_DAT_I[7:0];
          `AWM_ADR_TMO:    tmo_ms[7:0] <= WB_DAT_I[7:0];
          `AWM_ADR_TEMPLV: temp_lv <= WB_DAT_I[7:0];
          `AWM_ADR_OVLV:   ov_lv   <= WB_DAT_I[7:0];
          `AWM_ADR_UVLV:   uv_lv   <= WB_DAT_I[7:0];
          `AWM_ADR_BAND:   band[7:0] <= WB_DAT_I[7:0];
          `AWM_ADR_HIDX: begin
            if (WB_DAT_I[3:0] < `AWM_HIST_DEPTH) begin
              hidx <= WB_DAT_I[3:0];
            end
          end
          default: begin
          end
        endcase
      end
      if (wr && WB_SEL[1]) begin
        if (WB_ADR == `AWM_ADR_TMO) begin
          tmo_ms[15:8] <= WB_DAT_I[15:8];
        end
        if (WB_ADR == `AWM_ADR_BAND) begin
          band[15:8] <= WB_DAT_I[15:8];
        end
      end
    end
  end

  // Every access is answered one cycle after it appears; unmapped reads give zero.
  always @(posedge CLK) begin
    if (!RESETN) begin
      WB_ACK   <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK <= req;
      if (req && !WB_WE) begin
        case (WB_ADR)
          `AWM_ADR_CTRL:   WB_DAT_O <= {30'h00000000, ctrl};
          `AWM_ADR_ERRTH:  WB_DAT_O <= {24'h000000, err_th};
          `AWM_ADR_TMO:    WB_DAT_O <= {16'h0000, tmo_ms};
          `AWM_ADR_TEMPLV: WB_DAT_O <= {24'h000000, temp_lv};
          `AWM_ADR_OVLV:   WB_DAT_O <= {24'h000000, ov_lv};
          `AWM_ADR_UVLV:   WB_DAT_O <= {24'h000000, uv_lv};
          `AWM_ADR_BAND:   WB_DAT_O <= {16'h0000, band};
          `AWM_ADR_ALMST:  WB_DAT_O <= {21'h000000, alm_reset, alm_excite, alm_active, alm_code};
          `AWM_ADR_WNGST:  WB_DAT_O <= {20'h00000, hcount, 2'h0, wcond};
          `AWM_ADR_HIDX:   WB_DAT_O <= {28'h0000000, hidx};
          `AWM_ADR_HDAT:   WB_DAT_O <= {24'h000000, hvalid ? hdata : 8'h00};
          default:         WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // awm_top
